// ==== slb_boot_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "slb_consts.vh"
// ****************************************
// boot mode and log decode
// ****************************************
module slb_boot_decode (
   input wire [2:0] strap,
   input wire [1:0] printCtl,
   output reg bootFlash,
   output reg bootDownload,
   output reg comboInvalid,
   output reg logEnable
);
   reg sel;
   reg logCtl;
   reg mode;

   // mode select from latched bits
   always @* begin
      sel = strap[`SLB_BIT_SELECT];
      logCtl = strap[`SLB_BIT_LOGCTL];
      mode = strap[`SLB_BIT_MODE];
      bootFlash = sel & mode;
      bootDownload = sel & ~mode & logCtl;
      comboInvalid = ~logCtl & ~mode;
      case (printCtl)
         `SLB_PRINT_ALWAYS: logEnable = 1'b1;
         `SLB_PRINT_LOW: logEnable = ~logCtl;
         `SLB_PRINT_HIGH: logEnable = logCtl;
         `SLB_PRINT_NEVER: logEnable = 1'b0;
         default: logEnable = 1'b0;
      endcase
   end
endmodule // slb_boot_decode
`default_nettype wire

// ==== slb_consts.vh ====
`ifndef SLB_CONSTS_VH
`define SLB_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define SLB_ADDR_STRAP 4'h0
`define SLB_ADDR_BOOT 4'h4
`define SLB_ADDR_PADCTL 4'h8
// ****************************************
// strap status field positions
// ****************************************
`define SLB_BIT_SELECT 0
`define SLB_BIT_LOGCTL 1
`define SLB_BIT_MODE 2
// ****************************************
// boot status field positions
// ****************************************
`define SLB_BIT_FLASH 0
`define SLB_BIT_DOWNLOAD 1
`define SLB_BIT_INVALID 2
`define SLB_BIT_LOGEN 3
`define SLB_BIT_FUSE 4
`define SLB_BIT_CHIPON 6
// ****************************************
// pad control field positions
// ****************************************
`define SLB_BIT_PADOUT 0
`define SLB_BIT_PADOE 8
// ****************************************
// reset values
// ****************************************
`define SLB_STRAP_RST 3'h4
`define SLB_PADCTL_RST 32'h00000000
// ****************************************
// print control fuse codes
// ****************************************
`define SLB_PRINT_ALWAYS 2'h0
`define SLB_PRINT_LOW 2'h1
`define SLB_PRINT_HIGH 2'h2
`define SLB_PRINT_NEVER 2'h3
// ****************************************
// bus answers
// ****************************************
`define SLB_RESP_OKAY 2'h0
`define SLB_RESP_DECERR 2'h3
`endif

// ==== slb_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module slb_pad_model (
   input wire logic clk,
   input wire logic [2:0] lvl,
   input wire logic [2:0] drv,
   input wire logic [2:0] padOut,
   input wire logic [2:0] padOe,
   input wire logic pullUp,
   output logic [2:0] padIn
);
   logic flip = 1'b0;
   // undriven pad without pull wanders
   always @(posedge clk) flip <= ~flip;
   // resolve each pad from all drivers
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         if (padOe[k]) padIn[k] = padOut[k];
         else if (drv[k]) padIn[k] = lvl[k];
         else if (k == 2 && pullUp) padIn[k] = 1'b1;
         else padIn[k] = flip;
      end
   end
endmodule // slb_pad_model
`default_nettype wire

// ==== slb_strap_latch.v ====
// Function
// - every system reset samples each strap pin, held until power down
// - sampling on por, rtc wdt, brownout, super wdt, glitch resets
// - boot mode pin has pull-up; floating reads as 1
// - after reset pins return to gpio; later activity ignored
// - latched straps readable in read-only strap status register
// - boot select 1 for both boots; log strap ignored for flash
// - log 0 with mode 0 is invalid and is flagged
// - fuse 0 prints always, 1 prints on strap 0, 2 on strap 1
// - chip enable high powers on, low powers off
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slb_consts.vh"
module slb_strap_latch (
   input wire clk,
   input wire rst,
   // system reset sources, asynchronous pins
   input wire porRst,
   input wire rtcWdtRst,
   input wire brownoutRst,
   input wire superWdtRst,
   input wire glitchRst,
   input wire chipEnable,
   // strap pads
   input wire bootSelectStrapIn,
   output reg bootSelectStrapOut,
   output reg bootSelectStrapOe,
   input wire logControlStrapIn,
   output reg logControlStrapOut,
   output reg logControlStrapOe,
   input wire bootModeStrapIn,
   output reg bootModeStrapOut,
   output reg bootModeStrapOe,
   output reg bootModePullUp,
   // fuse field, same clock
   input wire [1:0] printControlFuse,
   // decoded results
   output reg sysResetActive,
   output reg chipOn,
   output reg bootFlash,
   output reg bootDownload,
   output reg comboInvalid,
   output reg romLogEnable,
   // axi4-lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ****************************************
   // declarations
   // ****************************************
   wire [5:0] rstSync;
   wire [2:0] padSync;
   wire sysRstNow;
   reg sysRst_q;
   reg [2:0] sample_q;
   reg [2:0] strap_q;
   reg [31:0] padCtl_q;
   wire decFlash;
   wire decDownload;
   wire decInvalid;
   wire decLog;
   reg [3:0] awAddr_q;
   reg awFull_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg wFull_q;
   wire awTake;
   wire wTake;
   wire doWrite;
   wire arTake;
   reg awFull_d;
   reg wFull_d;
   reg bValid_d;
   reg rValid_d;
   reg [31:0] readWord;
   reg readHit;

   // ****************************************
   // helpers
   // ****************************************
   // byte lane merge for register writes
   function [31:0] mergeBytes;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         mergeBytes = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               mergeBytes[8*i +: 8] = data[8*i +: 8];
            end
         end
      end
   endfunction

   // address decode, true when offset is mapped
   function isMapped;
      input [3:0] addr;
      begin
         isMapped = (addr == `SLB_ADDR_STRAP) ||
            (addr == `SLB_ADDR_BOOT) ||
            (addr == `SLB_ADDR_PADCTL);
      end
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   // reset sources plus chip enable
   slb_sync #(
      .WIDTH(6),
      .RST_VAL(6'h1F)
   ) uRstSync (
      .clk(clk),
      .rst(rst),
      .asyncIn({chipEnable, glitchRst, superWdtRst, brownoutRst,
         rtcWdtRst, porRst}),
      .syncOut(rstSync)
   );

   // strap pad levels
   slb_sync #(
      .WIDTH(3),
      .RST_VAL(`SLB_STRAP_RST)
   ) uPadSync (
      .clk(clk),
      .rst(rst),
      .asyncIn({bootModeStrapIn, logControlStrapIn, bootSelectStrapIn}),
      .syncOut(padSync)
   );

   // any system reset source or chip powered off
   assign sysRstNow = (|rstSync[4:0]) | ~rstSync[5];

   // ****************************************
   // strap capture
   // ****************************************
   // sample while in reset, commit at release
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sysRst_q <= 1'b1;
         sample_q <= `SLB_STRAP_RST;
         strap_q <= `SLB_STRAP_RST;
      end else begin
         sysRst_q <= sysRstNow;
         if (sysRstNow) begin
            sample_q <= padSync;
         end
         if (~rstSync[5]) begin
            strap_q <= `SLB_STRAP_RST;
         end else if (sysRst_q & ~sysRstNow) begin
            strap_q <= sample_q;
         end
      end
   end

   // ****************************************
   // decode
   // ****************************************
   slb_boot_decode uDecode (
      .strap(strap_q),
      .printCtl(printControlFuse),
      .bootFlash(decFlash),
      .bootDownload(decDownload),
      .comboInvalid(decInvalid),
      .logEnable(decLog)
   );

   // registered results and pad drive
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sysResetActive <= 1'b1;
         chipOn <= 1'b0;
         bootFlash <= 1'b0;
         bootDownload <= 1'b0;
         comboInvalid <= 1'b0;
         romLogEnable <= 1'b0;
         bootSelectStrapOut <= 1'b0;
         bootSelectStrapOe <= 1'b0;
         logControlStrapOut <= 1'b0;
         logControlStrapOe <= 1'b0;
         bootModeStrapOut <= 1'b0;
         bootModeStrapOe <= 1'b0;
         bootModePullUp <= 1'b1;
      end else begin
         sysResetActive <= sysRstNow;
         chipOn <= rstSync[5];
         bootFlash <= decFlash;
         bootDownload <= decDownload;
         comboInvalid <= decInvalid;
         romLogEnable <= decLog;
         bootModePullUp <= 1'b1;
         // pads released during reset, gpio afterwards
         bootSelectStrapOut <= padCtl_q[`SLB_BIT_PADOUT + 0];
         logControlStrapOut <= padCtl_q[`SLB_BIT_PADOUT + 1];
         bootModeStrapOut <= padCtl_q[`SLB_BIT_PADOUT + 2];
         bootSelectStrapOe <= ~sysRstNow & padCtl_q[`SLB_BIT_PADOE + 0];
         logControlStrapOe <= ~sysRstNow & padCtl_q[`SLB_BIT_PADOE + 1];
         bootModeStrapOe <= ~sysRstNow & padCtl_q[`SLB_BIT_PADOE + 2];
      end
   end

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   assign awTake = s_axi_awvalid & s_axi_awready;
   assign wTake = s_axi_wvalid & s_axi_wready;
   assign doWrite = awFull_q & wFull_q & ~s_axi_bvalid;

   // holding state of address, data, response
   always @* begin
      awFull_d = doWrite ? 1'b0 : (awFull_q | awTake);
      wFull_d = doWrite ? 1'b0 : (wFull_q | wTake);
      if (doWrite) begin
         bValid_d = 1'b1;
      end else if (s_axi_bready) begin
         bValid_d = 1'b0;
      end else begin
         bValid_d = s_axi_bvalid;
      end
   end

   // write handshake and register update
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         awAddr_q <= 4'h0;
         awFull_q <= 1'b0;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         wFull_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SLB_RESP_OKAY;
         padCtl_q <= `SLB_PADCTL_RST;
      end else begin
         if (awTake) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         awFull_q <= awFull_d;
         wFull_q <= wFull_d;
         s_axi_awready <= ~awFull_d & ~bValid_d;
         s_axi_wready <= ~wFull_d & ~bValid_d;
         s_axi_bvalid <= bValid_d;
         if (doWrite) begin
            if (awAddr_q == `SLB_ADDR_PADCTL) begin
               padCtl_q <= mergeBytes(padCtl_q, wData_q, wStrb_q);
               s_axi_bresp <= `SLB_RESP_OKAY;
            end else if (isMapped(awAddr_q)) begin
               s_axi_bresp <= `SLB_RESP_OKAY; // read-only, write dropped
            end else begin
               s_axi_bresp <= `SLB_RESP_DECERR;
            end
         end
      end
   end

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   assign arTake = s_axi_arvalid & s_axi_arready;

   // read mux
   always @* begin
      readWord = 32'h00000000;
      readHit = 1'b1;
      case (s_axi_araddr)
         `SLB_ADDR_STRAP: begin
            readWord[2:0] = strap_q;
         end
         `SLB_ADDR_BOOT: begin
            readWord[`SLB_BIT_FLASH] = bootFlash;
            readWord[`SLB_BIT_DOWNLOAD] = bootDownload;
            readWord[`SLB_BIT_INVALID] = comboInvalid;
            readWord[`SLB_BIT_LOGEN] = romLogEnable;
            readWord[`SLB_BIT_FUSE +: 2] = printControlFuse;
            readWord[`SLB_BIT_CHIPON] = chipOn;
         end
         `SLB_ADDR_PADCTL: begin
            readWord = padCtl_q;
         end
         default: begin
            readHit = 1'b0;
         end
      endcase
   end

   // next read valid
   always @* begin
      if (arTake) begin
         rValid_d = 1'b1;
      end else if (s_axi_rready) begin
         rValid_d = 1'b0;
      end else begin
         rValid_d = s_axi_rvalid;
      end
   end

   // read handshake and data capture
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SLB_RESP_OKAY;
      end else begin
         s_axi_arready <= ~rValid_d;
         s_axi_rvalid <= rValid_d;
         if (arTake) begin
            s_axi_rdata <= readWord;
            s_axi_rresp <= readHit ? `SLB_RESP_OKAY : `SLB_RESP_DECERR;
         end
      end
   end
endmodule // slb_strap_latch
`default_nettype wire

// ==== slb_strap_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "slb_consts.vh"
module slb_strap_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic rtcWdtRst,
   input wire logic brownoutRst,
   input wire logic superWdtRst,
   input wire logic glitchRst,
   input wire logic chipEnable,
   input wire logic bootSelectStrapOe,
   input wire logic logControlStrapOe,
   input wire logic bootModeStrapOe,
   input wire logic bootModePullUp,
   input wire logic [1:0] printControlFuse,
   input wire logic sysResetActive,
   input wire logic chipOn,
   input wire logic bootFlash,
   input wire logic bootDownload,
   input wire logic comboInvalid,
   input wire logic romLogEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************************
   // pads, power and reset sources
   // ****************************************
   pad_release_a: assert property (sysResetActive && $past(sysResetActive) |->
      !(bootSelectStrapOe || logControlStrapOe || bootModeStrapOe))
      else $error("strap pad driven in system reset");
   pull_up_a: assert property (bootModePullUp)
      else $error("boot mode pull-up off");
   chip_off_a: assert property ((!chipEnable)[*5] |-> !chipOn && sysResetActive)
      else $error("chip still on with enable low");
   chip_on_a: assert property (chipEnable[*5] |-> chipOn)
      else $error("chip off with enable high");
   reset_src_a: assert property (
      (porRst || rtcWdtRst || brownoutRst || superWdtRst || glitchRst)[*5] |-> sysResetActive)
      else $error("reset source not seen");
   // ****************************************
   // latched decode
   // ****************************************
   latch_hold_a: assert property ((!sysResetActive)[*4] |=>
      $stable({bootFlash, bootDownload, comboInvalid}))
      else $error("boot decode moved outside reset");
   boot_excl_a: assert property (bootFlash |-> !bootDownload)
      else $error("flash and download together");
   bad_combo_a: assert property (comboInvalid |-> !bootFlash && !bootDownload)
      else $error("boot chosen on invalid straps");
   log_never_a: assert property ((printControlFuse == `SLB_PRINT_NEVER)[*3] |-> !romLogEnable)
      else $error("log on with fuse never");
   log_always_a: assert property (
      (printControlFuse == `SLB_PRINT_ALWAYS && !sysResetActive)[*4] |-> romLogEnable)
      else $error("log off with fuse always");
endmodule // slb_strap_props
bind slb_strap_latch slb_strap_props chk_u (.clk(clk), .rst(rst), .porRst(porRst),
   .rtcWdtRst(rtcWdtRst), .brownoutRst(brownoutRst), .superWdtRst(superWdtRst),
   .glitchRst(glitchRst), .chipEnable(chipEnable), .bootSelectStrapOe(bootSelectStrapOe),
   .logControlStrapOe(logControlStrapOe), .bootModeStrapOe(bootModeStrapOe),
   .bootModePullUp(bootModePullUp), .printControlFuse(printControlFuse),
   .sysResetActive(sysResetActive), .chipOn(chipOn), .bootFlash(bootFlash),
   .bootDownload(bootDownload), .comboInvalid(comboInvalid), .romLogEnable(romLogEnable));
`default_nettype wire

// ==== slb_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two flop synchroniser
// ****************************************
module slb_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         syncOut <= RST_VAL;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule // slb_sync
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "slb_consts.vh"
module tb_top;
   logic clk = 1'b0, rst = 1'b1, chipEnable = 1'b1;
   logic [4:0] srcs = 5'h1;
   logic [1:0] fuse = 2'h0, bresp, rresp, resp;
   logic [2:0] lvl = 3'h7, drv = 3'h7, padIn, padOut, padOe, s;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0, rdata, got, e;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pullUp;
   logic sysResetActive, chipOn, bootFlash, bootDownload, comboInvalid, romLogEnable;
   integer n_fail = 0, comparisons = 0, cycles = 0, seed = 39648, i;
   initial forever #2.5 clk = ~clk;
   slb_strap_latch dut_u (.clk(clk), .rst(rst), .porRst(srcs[0]), .rtcWdtRst(srcs[1]),
      .brownoutRst(srcs[2]), .superWdtRst(srcs[3]), .glitchRst(srcs[4]), .chipEnable(chipEnable),
      .bootSelectStrapIn(padIn[0]), .bootSelectStrapOut(padOut[0]), .bootSelectStrapOe(padOe[0]),
      .logControlStrapIn(padIn[1]), .logControlStrapOut(padOut[1]), .logControlStrapOe(padOe[1]),
      .bootModeStrapIn(padIn[2]), .bootModeStrapOut(padOut[2]), .bootModeStrapOe(padOe[2]),
      .bootModePullUp(pullUp), .printControlFuse(fuse), .sysResetActive(sysResetActive),
      .chipOn(chipOn), .bootFlash(bootFlash), .bootDownload(bootDownload),
      .comboInvalid(comboInvalid), .romLogEnable(romLogEnable), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   slb_pad_model pad_u (.clk(clk), .lvl(lvl), .drv(drv), .padOut(padOut), .padOe(padOe),
      .pullUp(pullUp), .padIn(padIn));
   // ****************************************
   // compare, bus and boot tasks
   // ****************************************
   task chk_word(input [31:0] g, input [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task chk_resp(input [1:0] g, input [1:0] x);
      comparisons++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d, output [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input [3:0] a, output [31:0] d, output [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   // one reset source with straps held, then pads wiggled
   task boot(input integer k, input [2:0] v, input [2:0] dv);
      lvl <= v;
      drv <= dv;
      srcs <= 5'h1 << k;
      repeat (6) @(posedge clk);
      srcs <= 5'h0;
      repeat (10) @(posedge clk);
      lvl <= ~v;
      drv <= 3'h7;
      repeat (6) @(posedge clk);
   endtask
   // boot status word: chipOn, fuse, log, invalid, download, flash
   function [31:0] exp_boot(input [2:0] t, input [1:0] f);
      exp_boot = {25'h0, 1'b1, f, f == `SLB_PRINT_ALWAYS || (f == `SLB_PRINT_LOW && !t[1]) ||
         (f == `SLB_PRINT_HIGH && t[1]), !t[1] && !t[2], t[0] && !t[2] && t[1], t[0] && t[2]};
   endfunction
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         results;
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 20; i++) begin
         s = (i < 8) ? i[2:0] : 3'($random(seed));
         fuse <= i[1:0];
         boot(i % 5, s, (i == 3) ? 3'h3 : 3'h7);
         if (i == 3) s[2] = 1'b1;
         e = exp_boot(s, i[1:0]);
         rd(`SLB_ADDR_STRAP, got, resp);
         chk_word(got, {29'h0, s});
         chk_resp(resp, `SLB_RESP_OKAY);
         rd(`SLB_ADDR_BOOT, got, resp);
         chk_word(got, e);
         chk_word({28'h0, romLogEnable, comboInvalid, bootDownload, bootFlash}, {28'h0, e[3:0]});
      end
      $display("boot test done");
      rd(`SLB_ADDR_PADCTL, got, resp);
      chk_word(got, `SLB_PADCTL_RST);
      wr(`SLB_ADDR_PADCTL, 32'h705, resp);
      chk_resp(resp, `SLB_RESP_OKAY);
      rd(`SLB_ADDR_PADCTL, got, resp);
      chk_word(got, 32'h705);
      chk_word({29'h0, padOut}, 32'h5);
      chk_word({29'h0, padOe}, 32'h7);
      boot(1, 3'h2, 3'h7);
      rd(`SLB_ADDR_STRAP, got, resp);
      chk_word(got, 32'h2);
      wr(`SLB_ADDR_STRAP, 32'h7, resp);
      chk_resp(resp, `SLB_RESP_OKAY);
      rd(`SLB_ADDR_STRAP, got, resp);
      chk_word(got, 32'h2);
      wr(4'hC, 32'h1, resp);
      chk_resp(resp, `SLB_RESP_DECERR);
      rd(4'hC, got, resp);
      chk_resp(resp, `SLB_RESP_DECERR);
      // byte lane 1 only: clears the pad enables, keeps the drive bits
      wstrb <= 4'h2;
      wr(`SLB_ADDR_PADCTL, 32'h0, resp);
      wstrb <= 4'hF;
      rd(`SLB_ADDR_PADCTL, got, resp);
      chk_word(got, 32'h5);
      chk_word({29'h0, padOe}, 32'h0);
      $display("bus test done");
      chipEnable <= 1'b0;
      lvl <= 3'h1;
      repeat (8) @(posedge clk);
      chk_word({30'h0, chipOn, sysResetActive}, 32'h1);
      chk_word({31'h0, pullUp}, 32'h1);
      rd(`SLB_ADDR_STRAP, got, resp);
      chk_word(got, {29'h0, `SLB_STRAP_RST});
      chipEnable <= 1'b1;
      repeat (10) @(posedge clk);
      lvl <= 3'h6;
      repeat (6) @(posedge clk);
      rd(`SLB_ADDR_BOOT, got, resp);
      chk_word(got, exp_boot(3'h1, fuse));
      $display("power test done");
      results;
   end
endmodule // tb_top
`default_nettype wire
